// >>> hw/ptmc_pkg.sv
// constants, register map and state carrier for the period timer mode control block
// assumes a single 25 MHz system clock and a 32-bit classic wishbone master
package ptmc_pkg;

	// ------------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [3:0] OFS_CTRL   = 4'h0;
	localparam logic [3:0] OFS_PERIOD = 4'h4;
	localparam logic [3:0] OFS_COUNT  = 4'h8;
	localparam logic [3:0] OFS_STATUS = 4'hC;

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int CTRL_MODE_LSB  = 0;
	localparam int CTRL_ON_BIT    = 7;
	localparam int CTRL_OUTPUT_POSTSCALE_FIELD_LSB = 8;
	localparam int CTRL_PRESCALER_SYNC_BIT_BIT = 12;
	localparam int CTRL_ENABLE_SYNC_BIT_BIT = 13;
	localparam int CTRL_CKPS_LSB  = 14;
	localparam int STAT_FLAG_BIT  = 0;
	localparam int STAT_IE_BIT    = 1;

	// ------------------------------------------------------------------
	// reset values and counts
	// ------------------------------------------------------------------
	localparam logic [7:0] PERIOD_RST   = 8'hFF;
	localparam logic [7:0] COUNT_RST    = 8'h00;
	localparam int         IRQ_SYNC_DEF = 2;

	// ------------------------------------------------------------------
	// mode groups (upper mode bits)
	// ------------------------------------------------------------------
	localparam logic [1:0] GRP_FREE = 2'h0;
	localparam logic [1:0] GRP_ONE  = 2'h1;
	localparam logic [1:0] GRP_MONO = 2'h2;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} ptmc_wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] rdata;
		logic        timer_on;
		logic [4:0]  mode;
		logic [3:0]  output_postscale_field;
		logic [2:0]  ckps;
		logic        prescaler_sync_bit;
		logic        enable_sync_bit;
		logic [7:0]  period;
		logic [7:0]  count;
		logic        ie;
		logic        flag;
		logic        on_eff;
		logic        tin_prev;
		logic        ers_q;
		logic        started;
		logic [6:0]  pre;
		logic [3:0]  post;
		logic        tick_d;
		logic        post_pulse;
		logic [1:0]  irq_pipe;
	} ptmc_state_t;

endpackage

// >>> hw/ptmc_timer.sv
// period timer with hardware limit: mode decode, postscaler, interrupt flag, wishbone slave
// assumes timer_clk_in, external_reset_signal and debug_mode are synchronous to clk
`timescale 1ns/1ps

module ptmc_timer
	import ptmc_pkg::*;
#(
	parameter int IRQ_SYNC = IRQ_SYNC_DEF
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire ptmc_wb_req_t wb_req,
	output logic              wb_ack,
	output logic [31:0]       wb_dat_o,
	input  wire logic         timer_clk_in,
	input  wire logic         external_reset_signal,
	input  wire logic         debug_mode,
	output logic              irq_out,
	output logic              postscaled_out,
	output logic [7:0]        count_value
);

	// ------------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------------
	if (IRQ_SYNC < 1 || IRQ_SYNC > 2) begin : g_bad_sync
		$error("IRQ_SYNC must be 1 or 2");
	end

	ptmc_state_t s_reg;
	ptmc_state_t s_next;

	logic        bus_wr;
	logic [31:0] wmask;
	logic [31:0] ctrl_img;
	logic [31:0] stat_img;
	logic [31:0] merged;
	logic        ctrl_wr;
	logic        count_wr;
	logic        flag_clr;
	logic        tin_rise;
	logic [6:0]  pre_mask;
	logic        raw_tick;
	logic        tick;
	logic        ers_now;
	logic        ers_rise;
	logic        ers_fall;
	logic        match;
	logic [1:0]  grp;
	logic [2:0]  sub;
	logic        run;
	logic        rst_cnt;
	logic        start;
	logic        oneshot;
	logic        mono;
	logic        pulse;

	// ------------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		// bus slave: ack one cycle after the request, dropped the next cycle
		s_next.ack = wb_req.cyc & wb_req.stb & ~s_reg.ack;
		bus_wr     = s_reg.ack & wb_req.cyc & wb_req.stb & wb_req.we;
		wmask      = {{8{wb_req.sel[3]}}, {8{wb_req.sel[2]}},
		              {8{wb_req.sel[1]}}, {8{wb_req.sel[0]}}};
		ctrl_img   = 32'h0000_0000;
		ctrl_img[CTRL_MODE_LSB +: 5]  = s_reg.mode;
		ctrl_img[CTRL_ON_BIT]         = s_reg.timer_on;
		ctrl_img[CTRL_OUTPUT_POSTSCALE_FIELD_LSB +: 4] = s_reg.output_postscale_field;
		ctrl_img[CTRL_PRESCALER_SYNC_BIT_BIT]      = s_reg.prescaler_sync_bit;
		ctrl_img[CTRL_ENABLE_SYNC_BIT_BIT]      = s_reg.enable_sync_bit;
		ctrl_img[CTRL_CKPS_LSB +: 3]  = s_reg.ckps;
		stat_img   = 32'h0000_0000;
		stat_img[STAT_FLAG_BIT] = s_reg.flag;
		stat_img[STAT_IE_BIT]   = s_reg.ie;
		if (!s_reg.ack) begin
			unique case (wb_req.adr)
				OFS_CTRL:   s_next.rdata = ctrl_img;
				OFS_PERIOD: s_next.rdata = {24'h00_0000, s_reg.period};
				OFS_COUNT:  s_next.rdata = {24'h00_0000, s_reg.count};
				OFS_STATUS: s_next.rdata = stat_img;
				default:    s_next.rdata = 32'h0000_0000;
			endcase
		end
		ctrl_wr  = bus_wr && wb_req.adr == OFS_CTRL && wb_req.sel != 4'h0;
		count_wr = bus_wr && wb_req.adr == OFS_COUNT && wb_req.sel[0];
		flag_clr = bus_wr && wb_req.adr == OFS_STATUS && wb_req.sel[0]
		           && wb_req.dat[STAT_FLAG_BIT];
		merged   = (ctrl_img & ~wmask) | (wb_req.dat & wmask);

		// prescaler on rising edges of the timer input
		s_next.tin_prev = timer_clk_in;
		tin_rise = timer_clk_in & ~s_reg.tin_prev;
		pre_mask = 7'((8'h01 << s_reg.ckps) - 8'h01);
		raw_tick = tin_rise & (&(s_reg.pre | ~pre_mask));
		if (tin_rise) begin
			s_next.pre = raw_tick ? 7'h00 : s_reg.pre + 7'h01;
		end
		// extra stage trades one clock of latency for a clean counter read
		s_next.tick_d = raw_tick;
		tick = s_reg.prescaler_sync_bit ? s_reg.tick_d : raw_tick;

		// enable resynchronisation
		if (s_reg.enable_sync_bit) begin
			if (tick) begin
				s_next.on_eff = s_reg.timer_on;
			end
		end else begin
			s_next.on_eff = s_reg.timer_on;
		end

		// external signal, sampled on timer ticks; frozen in debug
		ers_now  = debug_mode ? s_reg.ers_q : external_reset_signal;
		ers_rise = tick & ers_now & ~s_reg.ers_q;
		ers_fall = tick & ~ers_now & s_reg.ers_q;
		if (tick) begin
			s_next.ers_q = ers_now;
		end

		// mode decode
		grp     = s_reg.mode[4:3];
		sub     = s_reg.mode[2:0];
		match   = s_reg.count == s_reg.period;
		run     = 1'b0;
		rst_cnt = 1'b0;
		start   = 1'b0;
		oneshot = 1'b0;
		mono    = 1'b0;
		unique case (grp)
			GRP_FREE: begin
				run = 1'b1;
				unique case (sub)
					3'h1: run = ers_now;
					3'h2: run = ~ers_now;
					3'h3: rst_cnt = ers_rise | ers_fall;
					3'h4: rst_cnt = ers_rise;
					3'h5: rst_cnt = ers_fall;
					3'h6: rst_cnt = ~ers_now;
					3'h7: rst_cnt = ers_now;
					default: ;
				endcase
			end
			GRP_ONE: begin
				oneshot = 1'b1;
				unique case (sub)
					3'h0: start = 1'b1;
					3'h1: start = ers_rise;
					3'h2: start = ers_fall;
					3'h3: start = ers_rise | ers_fall;
					3'h4: begin
						start   = ers_rise;
						rst_cnt = s_reg.started & ers_rise;
					end
					3'h5: begin
						start   = ers_fall;
						rst_cnt = s_reg.started & ers_fall;
					end
					3'h6: begin
						start   = ers_rise;
						rst_cnt = s_reg.started & ~ers_now;
					end
					default: begin
						start   = ers_fall;
						rst_cnt = s_reg.started & ers_now;
					end
				endcase
				run = s_reg.started | start;
			end
			GRP_MONO: begin
				unique case (sub)
					3'h1: start = ers_rise;
					3'h2: start = ers_fall;
					3'h3: start = ers_rise | ers_fall;
					3'h6: begin
						start   = ers_now;
						rst_cnt = s_reg.started & ~ers_now;
					end
					3'h7: begin
						start   = ~ers_now;
						rst_cnt = s_reg.started & ers_now;
					end
					default: ;
				endcase
				mono    = sub inside {3'h1, 3'h2, 3'h3};
				oneshot = sub inside {3'h6, 3'h7};
				run     = (mono | oneshot) & (s_reg.started | start);
			end
			default: ;
		endcase

		// counter and postscaler
		pulse = 1'b0;
		if (!s_reg.on_eff) begin
			s_next.started = 1'b0;
		end else if (tick) begin
			if (rst_cnt) begin
				s_next.count = 8'h00;
				s_next.pre   = 7'h00;
				s_next.post  = 4'h0;
			end else if (run) begin
				s_next.started = 1'b1;
				if (match) begin
					s_next.count = 8'h00;
					if (s_reg.post == s_reg.output_postscale_field) begin
						pulse       = 1'b1;
						s_next.post = 4'h0;
					end else begin
						s_next.post = s_reg.post + 4'h1;
					end
					if (oneshot) begin
						s_next.timer_on = 1'b0;
						s_next.on_eff   = 1'b0;
						s_next.started  = 1'b0;
					end
					if (mono) begin
						s_next.started = 1'b0;
					end
				end else begin
					s_next.count = s_reg.count + 8'h01;
				end
			end
		end
		s_next.post_pulse = pulse;
		s_next.irq_pipe   = {s_reg.irq_pipe[0], pulse};

		// software writes; a ctrl or count write restarts both scalers
		if (ctrl_wr) begin
			s_next.mode     = merged[CTRL_MODE_LSB +: 5];
			s_next.timer_on = merged[CTRL_ON_BIT];
			s_next.output_postscale_field    = merged[CTRL_OUTPUT_POSTSCALE_FIELD_LSB +: 4];
			s_next.prescaler_sync_bit    = merged[CTRL_PRESCALER_SYNC_BIT_BIT];
			s_next.enable_sync_bit    = merged[CTRL_ENABLE_SYNC_BIT_BIT];
			s_next.ckps     = merged[CTRL_CKPS_LSB +: 3];
		end
		if (bus_wr && wb_req.adr == OFS_PERIOD && wb_req.sel[0]) begin
			s_next.period = wb_req.dat[7:0];
		end
		if (count_wr) begin
			s_next.count = wb_req.dat[7:0];
		end
		if (ctrl_wr || count_wr) begin
			s_next.pre  = 7'h00;
			s_next.post = 4'h0;
		end
		if (bus_wr && wb_req.adr == OFS_STATUS && wb_req.sel[0]) begin
			s_next.ie = wb_req.dat[STAT_IE_BIT];
		end
		if (flag_clr) begin
			s_next.flag = 1'b0;
		end
		// a match landing on the clear still leaves the flag set
		if (s_reg.irq_pipe[IRQ_SYNC-1]) begin
			s_next.flag = 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// state register
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_reg        <= '0;
			s_reg.period <= PERIOD_RST;
			s_reg.count  <= COUNT_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign wb_ack         = s_reg.ack;
	assign wb_dat_o       = s_reg.rdata;
	assign irq_out        = s_reg.flag & s_reg.ie;
	assign postscaled_out = s_reg.post_pulse;
	assign count_value    = s_reg.count;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_oneshot_end;
		tick && s_reg.on_eff && grp == GRP_ONE && run && !rst_cnt && match
		&& !ctrl_wr && !count_wr;
	endsequence

	sequence s_mono_end;
		tick && s_reg.on_eff && s_reg.timer_on && mono && run && !rst_cnt && match
		&& !ctrl_wr && !count_wr;
	endsequence

	bus_ack_pulse_a: assert property (wb_ack |=> !wb_ack)
		else $error("ack held longer than one cycle");
	irq_gate_a: assert property (!s_reg.ie |-> !irq_out)
		else $error("interrupt raised while disabled");
	flag_delay_a: assert property (s_reg.post_pulse |-> ##[1:2] s_reg.flag)
		else $error("flag not set after postscaler match");
	flag_sticky_a: assert property (s_reg.flag && !flag_clr |=> s_reg.flag)
		else $error("flag cleared without software");
	prescaler_sync_bit_stage_a: assert property (s_reg.prescaler_sync_bit && raw_tick |=> !s_reg.prescaler_sync_bit || tick)
		else $error("resynchronised tick missing");
	oneshot_stop_a: assert property (s_oneshot_end |=> !s_reg.timer_on && count_value == 8'h00)
		else $error("one-shot did not stop and clear enable");
	mono_stop_a: assert property (s_mono_end |=> s_reg.timer_on && count_value == 8'h00)
		else $error("monostable did not stop with enable kept");
	reserved_hold_a: assert property (grp == 2'h3 && !count_wr |=> $stable(count_value))
		else $error("counter moved in reserved mode");
	sw_gate_a: assert property (s_reg.mode == 5'h00 && !s_reg.on_eff && !count_wr
		|=> $stable(count_value))
		else $error("counter moved while disabled");
	hw_gate_a: assert property (tick && s_reg.on_eff && s_reg.mode == 5'h01 && !ers_now
		&& !count_wr |=> $stable(count_value))
		else $error("counter moved with gate low");
	level_reset_a: assert property (tick && s_reg.on_eff && s_reg.mode == 5'h06 && !ers_now
		&& !count_wr |=> count_value == 8'h00)
		else $error("counter not held in reset");
	edge_reset_a: assert property (s_reg.on_eff && s_reg.mode == 5'h04 && ers_rise
		&& !count_wr |=> count_value == 8'h00)
		else $error("rising edge did not reset counter");
	rearm_a: assert property (!s_reg.on_eff |=> !s_reg.started)
		else $error("start kept across disable");
	debug_freeze_a: assert property (debug_mode |=> $stable(s_reg.ers_q))
		else $error("external signal sampled in debug");
	enable_sync_bit_hold_a: assert property (s_reg.enable_sync_bit && !tick && !ctrl_wr |=> $stable(s_reg.on_eff))
		else $error("enable moved between timer ticks");
	enable_sync_bit_off_a: assert property (!s_reg.enable_sync_bit && !tick |=> s_reg.on_eff == $past(s_reg.timer_on))
		else $error("enable not following system clock");

endmodule

// >>> dv/ptmc_ext_src.sv
// far-side model: timer input clock and external trigger level
// assumes the bench commands run and the trigger level on clk
`timescale 1ns/1ps
module ptmc_ext_src (
	input  wire logic clk,
	input  wire logic nrst,
	input  wire logic run,
	input  wire logic lvl,
	output logic      tclk,
	output logic      rise,
	output logic      ers
);
	logic [2:0] div_reg;

	// timer clock stands still low outside runs, period 16 clk
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			div_reg <= 3'h0;
			tclk    <= 1'b0;
			rise    <= 1'b0;
			ers     <= 1'b0;
		end else begin
			div_reg <= run ? div_reg + 3'h1 : 3'h0;
			rise    <= run && div_reg == 3'h7 && !tclk;
			if (!run)
				tclk <= 1'b0;
			else if (div_reg == 3'h7)
				tclk <= !tclk;
			// level moves mid-period only, never beside a sampling edge
			if (!run || (div_reg == 3'h7 && tclk))
				ers <= lvl;
		end
	end
endmodule

// >>> dv/tb_top.sv
// self-checking bench for ptmc_timer: bus tasks, mode table, hand tests
// assumes ptmc_ext_src makes the timer clock and trigger level
`timescale 1ns/1ps
module tb_top import ptmc_pkg::*;;
	// ------------------------------------------------------------------
	// signals
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [15:0] ctrl;
		logic        ers;
		logic [7:0]  per;
		logic [3:0]  n;
		logic [7:0]  cnt;
		logic        on;
	} ptmc_row_t;
	logic         clk;
	logic         nrst;
	ptmc_wb_req_t wb_req;
	logic         wb_ack;
	logic [31:0]  wb_dat_o;
	logic         tclk;
	logic         rise;
	logic         ers;
	logic         run;
	logic         lvl;
	logic         debug_mode;
	logic         irq_out;
	logic         postscaled_out;
	logic [7:0]   count_value;
	logic [31:0]  rd;
	int           errors;
	int           check_count;
	int           pulses;
	ptmc_row_t    rows [16];

	ptmc_timer DUT (
		.clk(clk), .nrst(nrst), .wb_req(wb_req), .wb_ack(wb_ack), .wb_dat_o(wb_dat_o),
		.timer_clk_in(tclk), .external_reset_signal(ers), .debug_mode(debug_mode),
		.irq_out(irq_out), .postscaled_out(postscaled_out), .count_value(count_value)
	);
	ptmc_ext_src far_side (
		.clk(clk), .nrst(nrst), .run(run), .lvl(lvl), .tclk(tclk), .rise(rise), .ers(ers)
	);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// counted between edges, clear of the edge that launches the pulse
	always @(negedge clk) begin
		if (postscaled_out === 1'b1)
			pulses++;
	end

	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	task automatic conclude();
		$display("errors=%0d checks=%0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d,
			input logic [3:0] s);
		int i;
		@(posedge clk);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: s, dat: d};
		// ack looked at between edges, request released at the next rising edge
		for (i = 0; i < 20; i++) begin
			@(negedge clk);
			if (wb_ack === 1'b1)
				break;
		end
		if (wb_ack !== 1'b1) begin
			errors++;
			conclude();
		end
		@(posedge clk);
		rd = wb_dat_o;
		wb_req <= '0;
	endtask

	// sample 6 clk after the last tick so the count has settled
	task automatic ticks(input int n);
		int k;
		repeat (n) begin
			@(negedge clk);
			for (k = 0; k < 40 && rise !== 1'b1; k++)
				@(negedge clk);
			if (rise !== 1'b1) begin
				errors++;
				conclude();
			end
		end
		repeat (6) @(posedge clk);
	endtask

	// timer clock halted while configuring, so no tick lands mid-setup
	task automatic setup(input logic [15:0] c, input logic [7:0] p, input logic e);
		run <= 1'b0;
		lvl <= e;
		wb(1'b1, OFS_CTRL, {16'h0, c}, 4'hF);
		wb(1'b1, OFS_COUNT, 32'h0, 4'hF);
		wb(1'b1, OFS_PERIOD, {24'h0, p}, 4'hF);
		wb(1'b1, OFS_CTRL, {16'h0, c} | 32'h80, 4'hF);
		run <= 1'b1;
	endtask

	// ------------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------------
	initial begin
		nrst = 1'b0;
		wb_req = '0;
		run = 1'b0;
		lvl = 1'b0;
		debug_mode = 1'b0;
		errors = 0;
		check_count = 0;
		pulses = 0;
		rows = '{'{16'h0000,1'b0,8'h0A,4'h5,8'h05,1'b1}, '{16'h0000,1'b0,8'h03,4'h6,8'h02,1'b1},
			'{16'h0001,1'b1,8'h0A,4'h4,8'h04,1'b1}, '{16'h0001,1'b0,8'h0A,4'h4,8'h00,1'b1},
			'{16'h0002,1'b0,8'h0A,4'h4,8'h04,1'b1}, '{16'h0002,1'b1,8'h0A,4'h4,8'h00,1'b1},
			'{16'h0006,1'b0,8'h0A,4'h4,8'h00,1'b1}, '{16'h0006,1'b1,8'h0A,4'h4,8'h04,1'b1},
			'{16'h0007,1'b1,8'h0A,4'h4,8'h00,1'b1}, '{16'h0007,1'b0,8'h0A,4'h4,8'h04,1'b1},
			'{16'h0010,1'b0,8'h0A,4'h4,8'h00,1'b1}, '{16'h0015,1'b0,8'h0A,4'h4,8'h00,1'b1},
			'{16'h0018,1'b0,8'h0A,4'h4,8'h00,1'b1}, '{16'h0008,1'b0,8'h03,4'h6,8'h00,1'b0},
			'{16'h2000,1'b0,8'h0A,4'h5,8'h04,1'b1}, '{16'h1000,1'b0,8'h0A,4'h5,8'h05,1'b1}};
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		foreach (rows[i]) begin
			setup(rows[i].ctrl, rows[i].per, rows[i].ers);
			ticks(rows[i].n);
			chk({24'h0, count_value}, {24'h0, rows[i].cnt});
			wb(1'b0, OFS_COUNT, 32'h0, 4'hF);
			chk(rd, {24'h0, rows[i].cnt});
			wb(1'b0, OFS_CTRL, 32'h0, 4'hF);
			chk({31'h0, rd[CTRL_ON_BIT]}, {31'h0, rows[i].on});
		end
		for (int j = 0; j < 3; j++) begin
			setup(16'h0003 + j[15:0], 8'hFF, j != 0);
			ticks(6);
			lvl <= (j == 0);
			ticks(2);
			chk({31'h0, count_value < 8'h04}, {31'h0, j != 1});
			ticks(6);
		end
		// rising-edge reset, free-running and after a rising-edge start
		for (int j = 0; j < 2; j++) begin
			setup(j ? 16'h000C : 16'h0004, 8'hFF, 1'b0);
			ticks(6);
			lvl <= 1'b1;
			ticks(6);
			lvl <= 1'b0;
			ticks(6);
			lvl <= 1'b1;
			ticks(2);
			chk({24'h0, count_value}, 32'h1);
			lvl <= 1'b0;
			ticks(6);
		end
		for (int j = 0; j < 2; j++) begin
			setup(j ? 16'h0011 : 16'h0009, 8'h03, 1'b0);
			ticks(3);
			chk({24'h0, count_value}, 32'h0);
			lvl <= 1'b1;
			ticks(1);
			chk({24'h0, count_value}, 32'h1);
			ticks(4);
			chk({24'h0, count_value}, 32'h0);
			wb(1'b0, OFS_CTRL, 32'h0, 4'hF);
			chk({31'h0, rd[CTRL_ON_BIT]}, 32'(j));
			lvl <= 1'b0;
			ticks(6);
			lvl <= 1'b1;
			ticks(2);
			chk({24'h0, count_value}, j ? 32'h2 : 32'h0);
			wb(1'b1, OFS_CTRL, j ? 32'h11 : 32'h09, 4'hF);
			wb(1'b1, OFS_CTRL, j ? 32'h91 : 32'h89, 4'hF);
			ticks(4);
			chk({24'h0, count_value}, j ? 32'h2 : 32'h0);
			lvl <= 1'b0;
			ticks(6);
		end
		setup(16'h0001, 8'hFF, 1'b0);
		ticks(2);
		debug_mode <= 1'b1;
		lvl <= 1'b1;
		ticks(4);
		chk({24'h0, count_value}, 32'h0);
		debug_mode <= 1'b0;
		ticks(3);
		chk({31'h0, count_value != 8'h00}, 32'h1);
		wb(1'b1, OFS_STATUS, 32'h1, 4'hF);
		setup(16'h0100, 8'h01, 1'b0);
		pulses = 0;
		ticks(8);
		chk(32'(pulses), 32'h2);
		wb(1'b1, OFS_CTRL, 32'h0, 4'hF);
		wb(1'b0, OFS_STATUS, 32'h0, 4'hF);
		chk(rd, 32'h1);
		chk({31'h0, irq_out}, 32'h0);
		wb(1'b1, OFS_STATUS, 32'h2, 4'hF);
		repeat (2) @(posedge clk);
		chk({31'h0, irq_out}, 32'h1);
		repeat (20) @(posedge clk);
		wb(1'b0, OFS_STATUS, 32'h0, 4'hF);
		chk(rd, 32'h3);
		wb(1'b1, OFS_STATUS, 32'h3, 4'hF);
		wb(1'b0, OFS_STATUS, 32'h0, 4'hF);
		chk(rd, 32'h2);
		chk({31'h0, irq_out}, 32'h0);
		setup(16'h0000, 8'hFF, 1'b0);
		ticks(3);
		nrst <= 1'b0;
		repeat (4) @(posedge clk);
		chk({wb_ack, irq_out, postscaled_out, count_value}, 32'h0);
		nrst <= 1'b1;
		// disabled lanes and unmapped places must leave state alone
		wb(1'b1, OFS_PERIOD, 32'h55, 4'h0);
		wb(1'b0, OFS_PERIOD, 32'h0, 4'hF);
		chk(rd, 32'hFF);
		wb(1'b1, 4'h1, 32'h55, 4'hF);
		wb(1'b0, 4'h1, 32'h0, 4'hF);
		chk(rd, 32'h0);
		wb(1'b0, OFS_CTRL, 32'h0, 4'hF);
		chk(rd, 32'h0);
		conclude();
	end
endmodule
